// [hdl/tcrb_pkg.sv]
// Package for the second general timer: register map, control bit
// positions, reset values and timing constants.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package tcrb_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] TCRB_OFF_CONTROL = 8'h00_c8;
  localparam logic [7:0] TCRB_OFF_COUNT = 8'h00_d0;
  localparam logic [7:0] TCRB_OFF_RELOAD = 8'h00_d4;
  localparam logic [7:0] TCRB_OFF_MODE = 8'h00_d8;
  localparam logic [7:0] TCRB_OFF_IRQ_STATUS = 8'h00_e0;
  localparam logic [7:0] TCRB_OFF_IRQ_MASK = 8'h00_e4;

  // ----------------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------------
  localparam int TCRB_BIT_OVF = 7;
  localparam int TCRB_BIT_EXF = 6;
  localparam int TCRB_BIT_RCLK = 5;
  localparam int TCRB_BIT_TX_CLOCK_SELECT = 4;
  localparam int TCRB_BIT_EXEN = 3;
  localparam int TCRB_BIT_RUN = 2;
  localparam int TCRB_BIT_CSRC = 1;
  localparam int TCRB_BIT_CPRL = 0;

  // Mode register: up/down enable, baud generator rx/tx selects
  localparam int TCRB_BIT_UPDOWN = 0;
  localparam int TCRB_BIT_BRG_RX = 1;
  localparam int TCRB_BIT_BRG_TX = 2;

  // Interrupt status bits
  localparam int TCRB_IRQ_OVF = 0;
  localparam int TCRB_IRQ_EXF = 1;
  localparam int TCRB_IRQ_CAP = 2;
  localparam int TCRB_IRQ_W = 3;

  // ----------------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------------
  localparam logic [7:0] TCRB_CONTROL_RST = 8'h00;
  localparam logic [15:0] TCRB_COUNT_RST = 16'h0000;
  localparam logic [15:0] TCRB_COUNT_MAX = 16'hffff;
  localparam logic [1:0] TCRB_RESP_OKAY = 2'b00;
  localparam logic [1:0] TCRB_RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int TCRB_CLK_MHZ = 100;
  localparam int TCRB_PERIPH_NS = 20;
  localparam int TCRB_PERIPH_DIV =
    (TCRB_PERIPH_NS * TCRB_CLK_MHZ) / 1000;

endpackage

// [hdl/tcrb_sync.sv]
// Two-flop synchroniser with falling edge detect on the second stage.
// Assumes the input is asynchronous to aclk.
`timescale 1ns/1ps
module tcrb_sync
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and result
  input wire logic pin_in,
  output logic level_out,
  output logic fall_out
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Reset high so a held-high pin gives no false edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign fall_out = last_ff & ~sync_ff;

endmodule

// [hdl/tcrb_prescale.sv]
// Peripheral clock tick generator for timer mode counting.
// Assumes a free running aclk; tick is one cycle wide.
`timescale 1ns/1ps
module tcrb_prescale
  import tcrb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Tick out
  output logic tick
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic tick_ff;

  always_comb
  begin
    nxt_cnt = cnt_ff + 8'h01;
    if (cnt_ff == 8'(TCRB_PERIPH_DIV - 1))
      nxt_cnt = 8'h00;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= (cnt_ff == 8'(TCRB_PERIPH_DIV - 1));
    end
  end

  assign tick = tick_ff;

endmodule

// [hdl/tcrb_timer.sv]
// Second general timer: run control, count source, capture/reload on
// the trigger pin, flags with interrupt, baud clock selection.
// Assumes AXI4-Lite master on aclk; pins asynchronous to aclk.
`timescale 1ns/1ps
// Operation
// - Overflow flag set only when no baud select
// - Enabled falling trigger edge sets event flag only when no baud select
// - Event flag interrupts; only software clears
// - Up/down mode blocks event flag interrupt
// - Receive select picks timer one or two
// - Transmit select picks timer one or two
// - Rx and tx sources chosen independently
// - Source select: peripheral clock or pin falls
// - Control resets zero; bits singly writable
module tcrb_timer
  import tcrb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic count_input_pin,
  input wire logic external_trigger_pin,
  // Timer one overflow pulse, same clock domain
  input wire logic timer_one_overflow,
  // Serial baud clocks and interrupt
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic timer_irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0] control_ff;
  logic [2:0] mode_ff;
  logic [15:0] count_ff;
  logic [15:0] reload_ff;
  logic [TCRB_IRQ_W-1:0] irq_status_ff;
  logic [TCRB_IRQ_W-1:0] irq_mask_ff;
  logic irq_ff;
  logic rx_baud_ff;
  logic tx_baud_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;
  logic [15:0] nxt_count;
  logic periph_tick;
  logic count_fall;
  logic trig_fall;
  logic count_level;
  logic trig_level;
  logic baud_mode;
  logic count_tick;
  logic overflow;
  logic trig_act;
  logic set_ovf;
  logic set_exf;
  logic do_write;
  logic do_read;
  logic [7:0] wr_addr;
  logic [7:0] ctl_wr;
  logic ctl_sel;
  logic stat_rd;

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  tcrb_prescale u_prescale
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(periph_tick)
  );

  tcrb_sync u_sync_count
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(count_input_pin),
    .level_out(count_level),
    .fall_out(count_fall)
  );

  tcrb_sync u_sync_trig
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(external_trigger_pin),
    .level_out(trig_level),
    .fall_out(trig_fall)
  );

  // ----------------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------------
  assign baud_mode = control_ff[TCRB_BIT_RCLK] | control_ff[TCRB_BIT_TX_CLOCK_SELECT];
  assign count_tick = control_ff[TCRB_BIT_RUN] &
    (control_ff[TCRB_BIT_CSRC] ? count_fall : periph_tick);
  assign overflow = count_tick & (count_ff == TCRB_COUNT_MAX);
  // Trigger ignored when disabled or clocking the serial port
  assign trig_act = trig_fall & control_ff[TCRB_BIT_EXEN] &
    ~baud_mode;
  assign set_ovf = overflow & ~baud_mode;
  assign set_exf = trig_act;

  always_comb
  begin
    nxt_count = count_ff;
    if (count_tick)
      nxt_count = count_ff + 16'h0001;
    if (overflow)
      nxt_count = reload_ff;
    else if (trig_act && !control_ff[TCRB_BIT_CPRL])
      nxt_count = reload_ff;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_ff <= TCRB_COUNT_RST;
    else if (do_write && wr_addr == TCRB_OFF_COUNT)
      count_ff <= wdata_ff[15:0];
    else
      count_ff <= nxt_count;
  end

  // Capture overwrites the reload word, as the hardware shares it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reload_ff <= TCRB_COUNT_RST;
    else if (trig_act && control_ff[TCRB_BIT_CPRL])
      reload_ff <= count_ff;
    else if (do_write && wr_addr == TCRB_OFF_RELOAD)
      reload_ff <= wdata_ff[15:0];
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  assign ctl_sel = do_write && wr_addr == TCRB_OFF_CONTROL && wstrb_ff[0];
  assign ctl_wr = wdata_ff[7:0];

  // Byte write updates each bit alone; flags: set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      control_ff <= TCRB_CONTROL_RST;
    else
    begin
      if (ctl_sel)
        control_ff[5:0] <= ctl_wr[5:0];
      control_ff[TCRB_BIT_OVF] <= set_ovf |
        (ctl_sel ? ctl_wr[TCRB_BIT_OVF] : control_ff[TCRB_BIT_OVF]);
      control_ff[TCRB_BIT_EXF] <= set_exf |
        (ctl_sel ? ctl_wr[TCRB_BIT_EXF] : control_ff[TCRB_BIT_EXF]);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_ff <= 3'b000;
    else if (do_write && wr_addr == TCRB_OFF_MODE && wstrb_ff[0])
      mode_ff <= wdata_ff[2:0];
  end

  // ----------------------------------------------------------------------
  // Baud clocks
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_baud_ff <= 1'b0;
      tx_baud_ff <= 1'b0;
    end
    else
    begin
      // Independent rx and tx choices
      rx_baud_ff <= mode_ff[TCRB_BIT_BRG_RX] ? 1'b0 :
        (control_ff[TCRB_BIT_RCLK] ? overflow : timer_one_overflow);
      tx_baud_ff <= mode_ff[TCRB_BIT_BRG_TX] ? 1'b0 :
        (control_ff[TCRB_BIT_TX_CLOCK_SELECT] ? overflow : timer_one_overflow);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  assign stat_rd = do_read && s_axi_araddr == TCRB_OFF_IRQ_STATUS;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_ff <= '0;
    else
    begin
      irq_status_ff[TCRB_IRQ_OVF] <= set_ovf |
        (irq_status_ff[TCRB_IRQ_OVF] & ~stat_rd);
      irq_status_ff[TCRB_IRQ_EXF] <= (set_exf & ~mode_ff[TCRB_BIT_UPDOWN]) |
        (irq_status_ff[TCRB_IRQ_EXF] & ~stat_rd);
      irq_status_ff[TCRB_IRQ_CAP] <= (trig_act & control_ff[TCRB_BIT_CPRL]) |
        (irq_status_ff[TCRB_IRQ_CAP] & ~stat_rd);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_ff <= '0;
    else if (do_write && wr_addr == TCRB_OFF_IRQ_MASK && wstrb_ff[0])
      irq_mask_ff <= wdata_ff[TCRB_IRQ_W-1:0];
  end

  // Level stays high while a mask-enabled control flag stands (event flag: not in up/down mode), as on the core
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(irq_status_ff & irq_mask_ff) |
        (irq_mask_ff[TCRB_IRQ_OVF] & control_ff[TCRB_BIT_OVF]) |
        (irq_mask_ff[TCRB_IRQ_EXF] & control_ff[TCRB_BIT_EXF] &
         ~mode_ff[TCRB_BIT_UPDOWN]);
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_addr = awaddr_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end
    else if (s_axi_awvalid && awready_ff)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (s_axi_wvalid && wready_ff)
    begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end
    else
    begin
      awready_ff <= ~aw_held_ff & ~(s_axi_awvalid & awready_ff) & ~bvalid_ff;
      wready_ff <= ~w_held_ff & ~(s_axi_wvalid & wready_ff) & ~bvalid_ff;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= TCRB_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      case (wr_addr)
        TCRB_OFF_CONTROL, TCRB_OFF_COUNT, TCRB_OFF_RELOAD, TCRB_OFF_MODE,
        TCRB_OFF_IRQ_STATUS, TCRB_OFF_IRQ_MASK:
          bresp_ff <= TCRB_RESP_OKAY;
        default:
          bresp_ff <= TCRB_RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  assign do_read = s_axi_arvalid & arready_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      arready_ff <= 1'b0;
    else
      arready_ff <= ~rvalid_ff & ~do_read;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= TCRB_RESP_OKAY;
    end
    else if (do_read)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= TCRB_RESP_OKAY;
      case (s_axi_araddr)
        TCRB_OFF_CONTROL: rdata_ff <= {24'h00_0000, control_ff};
        TCRB_OFF_COUNT: rdata_ff <= {16'h0000, count_ff};
        TCRB_OFF_RELOAD: rdata_ff <= {16'h0000, reload_ff};
        TCRB_OFF_MODE: rdata_ff <= {27'h000_0000, trig_level, count_level,
                                    mode_ff};
        TCRB_OFF_IRQ_STATUS: rdata_ff <= {29'h0000_0000, irq_status_ff};
        TCRB_OFF_IRQ_MASK: rdata_ff <= {29'h0000_0000, irq_mask_ff};
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= TCRB_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign rx_baud_tick = rx_baud_ff;
  assign tx_baud_tick = tx_baud_ff;
  assign timer_irq = irq_ff;

endmodule

// [tb/tcrb_props.sv]
// Checker for the second timer: bus answers and baud tick sources.
// Assumes the bench offers write address and data at the same edge.
`timescale 1ns/1ps
module tcrb_props
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Baud
  input wire logic timer_one_overflow,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick
);
  import tcrb_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Select shadows: [1] timer two select, [0] generator select
  logic [1:0] rx_sel_ff;
  logic [1:0] tx_sel_ff;
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_sel_ff <= 2'b00;
      tx_sel_ff <= 2'b00;
    end
    // Low byte strobe off leaves the selects alone
    else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == TCRB_OFF_CONTROL)
    begin
      rx_sel_ff[1] <= s_axi_wdata[TCRB_BIT_RCLK];
      tx_sel_ff[1] <= s_axi_wdata[TCRB_BIT_TX_CLOCK_SELECT];
    end
    else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == TCRB_OFF_MODE)
    begin
      rx_sel_ff[0] <= s_axi_wdata[TCRB_BIT_BRG_RX];
      tx_sel_ff[0] <= s_axi_wdata[TCRB_BIT_BRG_TX];
    end
  end

  sequence s_wr_take;
    wr_go;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_aw_blocked: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_read_answer: assert property (s_rd_take |-> ##[1:3] s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_rx_from_one: assert property (
    rx_sel_ff == 2'b00 && $stable(rx_sel_ff) && timer_one_overflow
    |-> ##[1:2] rx_baud_tick) else $error("rx tick missing");
  a_tx_from_one: assert property (
    tx_sel_ff == 2'b00 && $stable(tx_sel_ff) && timer_one_overflow
    |-> ##[1:2] tx_baud_tick) else $error("tx tick missing");
  a_rx_gen_quiet: assert property (
    rx_sel_ff[0] && $past(rx_sel_ff[0], 2) |-> !rx_baud_tick)
    else $error("rx tick with generator");
  a_tx_gen_quiet: assert property (
    tx_sel_ff[0] && $past(tx_sel_ff[0], 2) |-> !tx_baud_tick)
    else $error("tx tick with generator");
endmodule

bind tcrb_timer tcrb_props u_props (.*);

// [tb/tcrb_partner.sv]
// Far side model: pins, timer one overflow, baud tick consumer.
// Assumes its tasks are called just after a rising edge.
`timescale 1ns/1ps
module tcrb_partner
(
  // Clock
  input wire logic aclk,
  // Baud ticks
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  // Pins and timer one
  output logic count_input_pin,
  output logic external_trigger_pin,
  output logic timer_one_overflow
);
  int rx_n = 0;
  int tx_n = 0;

  // Pins idle high so release of reset shows no fall
  initial
  begin
    count_input_pin = 1'b1;
    external_trigger_pin = 1'b1;
    timer_one_overflow = 1'b0;
  end

  always @(posedge aclk)
  begin
    rx_n += int'(rx_baud_tick === 1'b1);
    tx_n += int'(tx_baud_tick === 1'b1);
  end

  // Four low, four high: above the three cycle minimum
  task automatic fall(input bit trig);
    if (trig)
      external_trigger_pin <= 1'b0;
    else
      count_input_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    external_trigger_pin <= 1'b1;
    count_input_pin <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  task automatic one_ovf();
    timer_one_overflow <= 1'b1;
    @(posedge aclk);
    timer_one_overflow <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// [tb/tcrb_timer_test.sv]
// Self-checking bench for the second timer over its register bus.
// Assumes the partner model drives pins and timer one overflow.
`timescale 1ns/1ps
module tcrb_timer_test;
  import tcrb_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic count_input_pin, external_trigger_pin, timer_one_overflow;
  logic rx_baud_tick, tx_baud_tick, timer_irq;
  int fail_count = 0;
  int n_tests = 0;
  int rx0, tx0;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [1:0] rb;
  // Control, mode, rx tick expected, tx tick expected
  logic [15:0] tab [5] = '{16'h0003, 16'h2001, 16'h1002, 16'h0021,
    16'h0042};

  tcrb_timer dut (.*);
  tcrb_partner far (.*);

  always #5 aclk = ~aclk;

  task automatic test_done();
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic guard(input int n);
    if (n >= 60)
    begin
      chk("timeout", 0, 1);
      test_done();
    end
    else
      @(posedge aclk);
  endtask

  // -------------------------------------------------------------------
  // Bus cycles
  // -------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 60);
    rb = s_axi_bresp;
    s_axi_bready <= 1'b0;
    guard(n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 60);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    guard(n);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rv);
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge aclk);
    chk("irq", e, timer_irq);
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    rc(TCRB_OFF_CONTROL, 0);
    rc(TCRB_OFF_MODE, 8'h18);
    rd(8'hfc);
    chk("resp", TCRB_RESP_SLVERR, rr);
    chk("data", 0, rv);
    for (int b = 0; b < 6; b++)
    begin
      wr(TCRB_OFF_CONTROL, 1 << b);
      rc(TCRB_OFF_CONTROL, 1 << b);
    end
    wr(TCRB_OFF_CONTROL, 8'h1f, 4'h0);
    chk("bresp", TCRB_RESP_OKAY, rb);
    rc(TCRB_OFF_CONTROL, 8'h20);
    wr(8'hfc, 0);
    chk("bresp", TCRB_RESP_SLVERR, rb);
  endtask

  task automatic t_run();
    logic [31:0] v;
    wr(TCRB_OFF_COUNT, 0);
    wr(TCRB_OFF_CONTROL, 8'h04);
    repeat (40) @(posedge aclk);
    wr(TCRB_OFF_CONTROL, 0);
    rd(TCRB_OFF_COUNT);
    v = rv;
    chk("running", 1, v > 15 && v < 40);
    repeat (10) @(posedge aclk);
    rc(TCRB_OFF_COUNT, v);
    wr(TCRB_OFF_CONTROL, 8'h06);
    repeat (3) far.fall(0);
    rc(TCRB_OFF_COUNT, v + 3);
  endtask

  task automatic t_ovf();
    wr(TCRB_OFF_RELOAD, 16'h1234);
    wr(TCRB_OFF_COUNT, 16'hfffd);
    repeat (3) far.fall(0);
    rc(TCRB_OFF_CONTROL, 8'h86);
    rc(TCRB_OFF_COUNT, 16'h1234);
    wr(TCRB_OFF_IRQ_MASK, 1);
    rc(TCRB_OFF_IRQ_STATUS, 1);
    irq_is(1);
    wr(TCRB_OFF_CONTROL, 8'h06);
    irq_is(0);
    wr(TCRB_OFF_COUNT, 16'hffff);
    wr(TCRB_OFF_CONTROL, 8'h36);
    rx0 = far.rx_n;
    tx0 = far.tx_n;
    far.fall(0);
    rc(TCRB_OFF_CONTROL, 8'h36);
    rc(TCRB_OFF_COUNT, 16'h1234);
    chk("rx", rx0 + 1, far.rx_n);
    chk("tx", tx0 + 1, far.tx_n);
  endtask

  task automatic t_trig();
    wr(TCRB_OFF_COUNT, 8'h55);
    wr(TCRB_OFF_CONTROL, 8'h09);
    rd(TCRB_OFF_IRQ_STATUS);
    far.fall(1);
    rc(TCRB_OFF_CONTROL, 8'h49);
    rc(TCRB_OFF_RELOAD, 8'h55);
    wr(TCRB_OFF_IRQ_MASK, 2);
    rc(TCRB_OFF_IRQ_STATUS, 8'h06);
    irq_is(1);
    wr(TCRB_OFF_MODE, 1);
    irq_is(0);
    wr(TCRB_OFF_MODE, 0);
    irq_is(1);
    wr(TCRB_OFF_CONTROL, 8'h09);
    irq_is(0);
    wr(TCRB_OFF_RELOAD, 16'h1111);
    wr(TCRB_OFF_COUNT, 8'h77);
    wr(TCRB_OFF_CONTROL, 8'h08);
    far.fall(1);
    rc(TCRB_OFF_COUNT, 16'h1111);
    rc(TCRB_OFF_CONTROL, 8'h48);
    wr(TCRB_OFF_COUNT, 8'h77);
    wr(TCRB_OFF_CONTROL, 0);
    far.fall(1);
    rc(TCRB_OFF_CONTROL, 0);
    wr(TCRB_OFF_CONTROL, 8'h18);
    far.fall(1);
    rc(TCRB_OFF_CONTROL, 8'h18);
    rc(TCRB_OFF_COUNT, 8'h77);
  endtask

  task automatic t_baud();
    for (int i = 0; i < 5; i++)
    begin
      wr(TCRB_OFF_CONTROL, tab[i][15:8]);
      wr(TCRB_OFF_MODE, tab[i][7:4]);
      rx0 = far.rx_n;
      tx0 = far.tx_n;
      far.one_ovf();
      chk("rx", rx0 + tab[i][1], far.rx_n);
      chk("tx", tx0 + tab[i][0], far.tx_n);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_run();
    t_ovf();
    t_trig();
    t_baud();
    test_done();
  end
endmodule
